// *** cmd_unit_regs.svh ***
// constants for the spare io and print command unit
// assumes inclusion by bare name from the unit and bench files
`ifndef CMD_UNIT_REGS_SVH
`define CMD_UNIT_REGS_SVH
// ---------------------------------------------------------------
// register widths, reset values and parameter limits
// ---------------------------------------------------------------
`define SPARE_OUT_W 3
`define SPARE_IN_W 4
`define SPARE_OUT_RST 3'h0
`define SLOT_MAX 6'h20
`define SLOT_COUNT 33
`define SPARE_OUT_MAX 6'h07
`define NAME_CHARS 10
// ---------------------------------------------------------------
// response codes
// ---------------------------------------------------------------
`define RSP_OK 2'h0
`define RSP_REFUSED 2'h1
`define RSP_BAD_PARAM 2'h2
`endif

// *** cmd_unit_pkg.sv ***
// types shared by the command unit
// assumes cmd_unit_regs.svh is on the include path
`default_nettype none
package cmd_unit_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_NAME_QUERY = 4'h1,
    CMD_SPARE_OUT_SET = 4'h2,
    CMD_SPARE_OUT_QUERY = 4'h3,
    CMD_SPARE_IN_QUERY = 4'h4,
    CMD_PRINT_STOP = 4'h5,
    CMD_PRINT_START = 4'h6,
    CMD_PRINT_QUERY = 4'h7,
    CMD_TEMP_EN_SET = 4'h8,
    CMD_TEMP_EN_QUERY = 4'h9,
    CMD_SEQ_EN_SET = 4'ha,
    CMD_SEQ_EN_QUERY = 4'hb,
    CMD_LABEL_EN_SET = 4'hc,
    CMD_LABEL_EN_QUERY = 4'hd
  } cmd_t;
endpackage
`default_nettype wire

// *** slot_name_store.sv ***
// slot identifier store: 33 slots of ten 8-bit characters
// assumes writes come from the setting logic on the same clock
`default_nettype none
module slot_name_store
  import cmd_unit_pkg::*;
#(
  parameter int SLOTS = 33,
  parameter int CHARS = 10
)(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [5:0] wr_slot,
  input wire logic [CHARS*8-1:0] wr_name,
  input wire logic [5:0] rd_slot,
  output logic [CHARS*8-1:0] rd_name
);
  // name memory, loaded by the setting-define logic
  logic [CHARS*8-1:0] mem [SLOTS];
  // ---------------------------------------------------------------
  // write port and registered read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_slot] <= wr_name;
    end
    rd_name <= mem[rd_slot];
  end
endmodule
`default_nettype wire

// *** spare_io_print_command_unit.sv ***
// command unit for slot name query, spare io and printer control
// assumes decoded commands arrive one per cycle from the text parser
// Summary of operation
// R1: name query takes slot 0 to 32
// R2: name query returns stored slot identifier
// R3: spare output write sets three outputs
// R4: spare output query returns output states
// R5: spare input query returns four inputs
// R6: spare inputs sampled every cycle, query returns filtered value
// R7: most commands refused during measurement or calibration
// R8: printer start/stop refused only in calibration
// R9: stop clears printer function, query reports
// R10: start sets printer function, query reports
// R11: temperature print enable set, clear, query
// R12: temperature prints only with compensation active
// R13: sequence counter print enable set, clear, query
// R14: header label print enable set, clear, query
// R15: refused command changes nothing, reports refusal
`default_nettype none
`include "cmd_unit_regs.svh"
module spare_io_print_command_unit
  import cmd_unit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  // decoded command from parser
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [5:0] cmd_param,
  // state from measurement engine and calibration logic
  input wire logic meas_running,
  input wire logic cal_mode,
  input wire logic temp_comp_active,
  // slot name loading from the setting logic
  input wire logic name_wr_en,
  input wire logic [5:0] name_wr_slot,
  input wire logic [`NAME_CHARS*8-1:0] name_wr_data,
  // pins
  input wire logic [`SPARE_IN_W-1:0] spare_in_pin,
  output logic [`SPARE_OUT_W-1:0] spare_out_pin,
  // answer to host
  output logic rsp_valid,
  output logic [1:0] rsp_status,
  output logic [3:0] rsp_value,
  output logic [`NAME_CHARS*8-1:0] rsp_name,
  // print controls
  output logic printer_on,
  output logic print_temp,
  output logic print_seq_counter,
  output logic print_header_label
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0][`SPARE_IN_W-1:0] in_sync;
    logic [`SPARE_IN_W-1:0] in_stable;
    logic [`SPARE_OUT_W-1:0] spare_out;
    logic printer;
    logic temp_en;
    logic seq_en;
    logic label_en;
    logic rsp_v;
    logic [1:0] rsp_st;
    logic [3:0] rsp_val;
    logic name_pend;
    logic [`NAME_CHARS*8-1:0] name_ans;
  } state_t;
  state_t st_ff;
  state_t nxt_st;
  logic rst_n_int; // released reset
  logic [`NAME_CHARS*8-1:0] name_rd; // store read data
  logic [5:0] rd_slot; // store read address
  cmd_t cmd; // decoded command
  logic locked_all; // measurement or calibration
  logic [`SPARE_IN_W-1:0] in_now; // filtered inputs
  logic en_bit; // enable bit of the parameter

  assign cmd = cmd_t'(cmd_code);
  assign locked_all = meas_running | cal_mode;
  assign rd_slot = cmd_param;
  assign rst_n_int = st_ff.rst_sync[1];
  assign en_bit = cmd_param[0];

  // refusal test per command
  function automatic logic refused(input cmd_t c, input logic meas, input logic cal);
    logic r;
    r = 1'b0;
    if (c == CMD_PRINT_STOP || c == CMD_PRINT_START || c == CMD_PRINT_QUERY)
    begin
      r = cal; // R8
    end
    else if (c != CMD_NONE)
    begin
      r = meas | cal; // R7
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // name store
  // ---------------------------------------------------------------
  slot_name_store #(.SLOTS(`SLOT_COUNT), .CHARS(`NAME_CHARS)) u_names (
    .clk_sys(clk_sys),
    .wr_en(name_wr_en),
    .wr_slot(name_wr_slot),
    .wr_name(name_wr_data),
    .rd_slot(rd_slot),
    .rd_name(name_rd)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    nxt_st.in_sync = {st_ff.in_sync[1:0], spare_in_pin};
    // accept a change once second and third stages agree
    if (st_ff.in_sync[1] == st_ff.in_sync[2])
    begin
      nxt_st.in_stable = st_ff.in_sync[2];
    end
    in_now = st_ff.in_stable;
    nxt_st.rsp_v = 1'b0;
    nxt_st.name_pend = 1'b0;
    nxt_st.rsp_st = `RSP_OK;
    nxt_st.rsp_val = 4'h0;
    if (cmd_valid)
    begin
      nxt_st.rsp_v = 1'b1;
      if (refused(cmd, meas_running, cal_mode))
      begin
        nxt_st.rsp_st = `RSP_REFUSED; // R15
      end
      else
      begin
        unique case (cmd)
          CMD_NAME_QUERY:
          begin
            if (cmd_param > `SLOT_MAX) // R1
            begin
              nxt_st.rsp_st = `RSP_BAD_PARAM;
            end
            else
            begin
              nxt_st.rsp_v = 1'b0;
              nxt_st.name_pend = 1'b1; // R2
            end
          end
          CMD_SPARE_OUT_SET:
          begin
            if (cmd_param > `SPARE_OUT_MAX)
            begin
              nxt_st.rsp_st = `RSP_BAD_PARAM;
            end
            else
            begin
              nxt_st.spare_out = cmd_param[2:0]; // R3
            end
          end
          CMD_SPARE_OUT_QUERY: nxt_st.rsp_val = {1'b0, st_ff.spare_out}; // R4
          CMD_SPARE_IN_QUERY: nxt_st.rsp_val = in_now; // R5 R6
          CMD_PRINT_STOP: nxt_st.printer = 1'b0; // R9
          CMD_PRINT_START: nxt_st.printer = 1'b1; // R10
          CMD_PRINT_QUERY: nxt_st.rsp_val = {3'h0, st_ff.printer}; // R9 R10
          CMD_TEMP_EN_SET: nxt_st.temp_en = cmd_param[0]; // R11
          CMD_TEMP_EN_QUERY: nxt_st.rsp_val = {3'h0, st_ff.temp_en}; // R11
          CMD_SEQ_EN_SET: nxt_st.seq_en = cmd_param[0]; // R13
          CMD_SEQ_EN_QUERY: nxt_st.rsp_val = {3'h0, st_ff.seq_en}; // R13
          CMD_LABEL_EN_SET: nxt_st.label_en = cmd_param[0]; // R14
          CMD_LABEL_EN_QUERY: nxt_st.rsp_val = {3'h0, st_ff.label_en}; // R14
          default: nxt_st.rsp_st = `RSP_BAD_PARAM; // unknown code
        endcase
      end
    end
    // name read data arrives one cycle later
    if (st_ff.name_pend)
    begin
      nxt_st.rsp_v = 1'b1;
      nxt_st.name_ans = name_rd; // R2
    end
    // hold all state cleared until the reset shifter has filled
    if (!rst_n_int)
    begin
      nxt_st = '0;
      nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // registers; reset synchroniser lives in the same struct
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign spare_out_pin = st_ff.spare_out;
  assign printer_on = st_ff.printer;
  assign print_temp = st_ff.temp_en & temp_comp_active; // R12
  assign print_seq_counter = st_ff.seq_en;
  assign print_header_label = st_ff.label_en;
  assign rsp_valid = st_ff.rsp_v;
  assign rsp_status = st_ff.rsp_st;
  assign rsp_value = st_ff.rsp_val;
  assign rsp_name = st_ff.name_ans; // R2

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_lock_out; // R7
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_SPARE_OUT_SET && meas_running) |=> $stable(spare_out_pin);
  endproperty
  a_lock_out: assert property (p_lock_out) else $error("spare out changed while locked"); // R7
  property p_stop_meas; // R8
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_PRINT_STOP && !cal_mode) |=> !printer_on;
  endproperty
  a_stop_meas: assert property (p_stop_meas) else $error("stop not taken"); // R8
  property p_start; // R10
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_PRINT_START && !cal_mode) |=> printer_on;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // R10
  property p_cal_start; // R8
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_PRINT_START && cal_mode) |=> $stable(printer_on);
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("start taken in calibration"); // R8
  property p_out_set; // R3
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_SPARE_OUT_SET && !locked_all && cmd_param <= `SPARE_OUT_MAX)
      |=> {3'h0, spare_out_pin} == $past(cmd_param);
  endproperty
  a_out_set: assert property (p_out_set) else $error("spare out value wrong"); // R3
  // accepted enable write shows on the print line only with compensation
  property p_temp; // R12
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cmd == CMD_TEMP_EN_SET && !locked_all)
      |=> print_temp == ($past(en_bit) && temp_comp_active);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature print gating wrong"); // R12
  property p_refuse; // R15
    @(posedge clk_sys) disable iff (!rst_n_int)
    (cmd_valid && cal_mode && cmd != CMD_NONE) |=> rsp_valid && rsp_status == `RSP_REFUSED;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal not reported"); // R15
  sequence s_name_ok;
    cmd_valid && cmd == CMD_NAME_QUERY && !locked_all && cmd_param <= `SLOT_MAX;
  endsequence
  property p_name; // R1
    @(posedge clk_sys) disable iff (!rst_n_int)
    s_name_ok |=> !rsp_valid ##1 rsp_valid && rsp_status == `RSP_OK;
  endproperty
  a_name: assert property (p_name) else $error("name answer timing wrong"); // R1
endmodule
`default_nettype wire

// *** host_cmd_model.sv ***
// host side model: hands decoded commands to the unit, one per request
// assumes the bench raises go just after a rising edge of clk_sys
`default_nettype none
module host_cmd_model
  import cmd_unit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] code,
  input wire logic [5:0] prm,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [5:0] cmd_param
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_valid, cmd_code, cmd_param} = '0;
  // ---------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------
  // idle lines show the inverse of the last value, never a stale copy
  always @(posedge clk_sys)
  begin
    cmd_valid <= go;
    cmd_code <= go ? code : ~cmd_code;
    cmd_param <= go ? prm : ~cmd_param;
  end
endmodule
`default_nettype wire

// *** spare_io_print_command_unit_bench.sv ***
// self-checking bench for the spare io and print command unit
// assumes host_cmd_model and the design files are compiled first
`default_nettype none
`include "cmd_unit_regs.svh"
module spare_io_print_command_unit_bench
  import cmd_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
  logic clk_sys = 0, rst_n = 0, go = 0, meas = 0, cal = 0, tca = 0, nwe = 0;
  logic [3:0] code = 0, sin = 0, cmd_code, rsp_value, c_r;
  logic [5:0] prm = 0, nws = 0, cmd_param, p_r;
  logic [79:0] nwd = 0, rsp_name;
  logic [79:0] names [33]; // shadow of slot identifiers
  logic [2:0] spare_out_pin, o_s = 0;
  logic [1:0] rsp_status;
  logic cmd_valid, rsp_valid, printer_on, print_temp, print_seq_counter, print_header_label;
  logic pr_s = 0, t_s = 0, s_s = 0, l_s = 0, m_r, k_r;
  logic [31:0] rnd;
  int n_fail = 0, checked = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  host_cmd_model host (.clk_sys(clk_sys), .go(go), .code(code), .prm(prm),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param));
  spare_io_print_command_unit uut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_param(cmd_param), .meas_running(meas), .cal_mode(cal),
    .temp_comp_active(tca), .name_wr_en(nwe), .name_wr_slot(nws), .name_wr_data(nwd),
    .spare_in_pin(sin), .spare_out_pin(spare_out_pin), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .rsp_value(rsp_value), .rsp_name(rsp_name),
    .printer_on(printer_on), .print_temp(print_temp), .print_seq_counter(print_seq_counter),
    .print_header_label(print_header_label));
  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // printer start, stop and query survive a running measurement
  function automatic logic [1:0] est(input logic [3:0] c, input logic [5:0] p,
    input logic m, input logic k);
    if (k || (m && !(c inside {CMD_PRINT_STOP, CMD_PRINT_START, CMD_PRINT_QUERY})))
      return `RSP_REFUSED;
    if ((c == CMD_NAME_QUERY && p > `SLOT_MAX) || (c == CMD_SPARE_OUT_SET && p > `SPARE_OUT_MAX)
      || c == 4'h0 || c > 4'hd)
      return `RSP_BAD_PARAM;
    return `RSP_OK;
  endfunction
  // one command through the host model, then the outputs compared, rsp_value or rsp_name only when accepted
  task automatic run(input logic m, input logic k, input logic [3:0] c, input logic [5:0] p);
    logic [1:0] st;
    logic [3:0] v;
    st = est(c, p, m, k);
    v = 4'h0;
    go = 1;
    code = c;
    prm = p;
    meas = m;
    cal = k;
    @(posedge clk_sys);
    #2 go = 0;
    @(posedge clk_sys);
    // only an accepted name query answers one cycle later
    if (c == CMD_NAME_QUERY && st == `RSP_OK)
      @(posedge clk_sys);
    #2;
    case (c)
      CMD_SPARE_OUT_QUERY: v = {1'b0, o_s};
      CMD_SPARE_IN_QUERY: v = sin;
      CMD_PRINT_QUERY: v = {3'h0, pr_s};
      CMD_TEMP_EN_QUERY: v = {3'h0, t_s};
      CMD_SEQ_EN_QUERY: v = {3'h0, s_s};
      CMD_LABEL_EN_QUERY: v = {3'h0, l_s};
      default: v = 4'h0;
    endcase
    if (st == `RSP_OK)
      case (c)
        CMD_SPARE_OUT_SET: o_s = p[2:0];
        CMD_PRINT_STOP: pr_s = 0;
        CMD_PRINT_START: pr_s = 1;
        CMD_TEMP_EN_SET: t_s = p[0];
        CMD_SEQ_EN_SET: s_s = p[0];
        CMD_LABEL_EN_SET: l_s = p[0];
        default: ;
      endcase
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_status", st, rsp_status)
    if (st == `RSP_OK && c != CMD_NAME_QUERY)
      `CHK("rsp_value", v, rsp_value)
    if (st == `RSP_OK && c == CMD_NAME_QUERY)
      `CHK("rsp_name", names[p], rsp_name)
    `CHK("spare_out_pin", o_s, spare_out_pin)
    `CHK("print ctl", {pr_s, t_s & tca, s_s, l_s}, {printer_on, print_temp,
      print_seq_counter, print_header_label})
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rnd = 32'h000139ca;
    repeat (10) @(posedge clk_sys);
    #2 rst_n = 1;
    repeat (4) @(posedge clk_sys);
    #2;
    `CHK("reset outs", 7'h0, {spare_out_pin, printer_on, print_temp, print_seq_counter,
      print_header_label})
    nwe = 1;
    for (int i = 0; i < 33; i++)
    begin
      rnd = lfsr(rnd);
      nws = 6'(i);
      nwd = {rnd, rnd ^ 32'h5a5a5a5a, rnd[15:0]};
      names[i] = nwd;
      @(posedge clk_sys);
      #2;
    end
    nwe = 0;
    tca = 1;
    run(0, 0, CMD_SPARE_OUT_SET, 6'h07);
    run(0, 0, CMD_SPARE_OUT_SET, 6'h08);
    run(0, 0, CMD_NAME_QUERY, 6'h20);
    run(0, 0, CMD_NAME_QUERY, 6'h21);
    run(1, 0, CMD_PRINT_START, 6'h0);
    run(0, 1, CMD_PRINT_STOP, 6'h0);
    run(1, 0, CMD_SPARE_OUT_SET, 6'h02);
    run(0, 1, CMD_TEMP_EN_SET, 6'h01);
    run(0, 0, CMD_TEMP_EN_SET, 6'h01);
    for (int c = 1; c < 14; c++)
      run(0, 0, 4'(c), 6'h1);
    run(0, 0, 4'hf, 6'h0);
    // mid-run reset: every held setting drops back to zero
    rst_n = 0;
    @(posedge clk_sys);
    #2 rst_n = 1;
    {o_s, pr_s, t_s, s_s, l_s} = '0;
    repeat (3) @(posedge clk_sys);
    #2;
    `CHK("mid reset outs", 7'h0, {spare_out_pin, printer_on, print_temp, print_seq_counter,
      print_header_label})
    for (int i = 0; i < 300; i++)
    begin
      rnd = lfsr(rnd);
      c_r = 4'h1 + 4'(rnd[7:0] % 13);
      p_r = 6'(rnd[15:8] % 40);
      m_r = rnd[16] & rnd[17];
      k_r = rnd[18] & rnd[19] & rnd[20];
      tca = rnd[21];
      sin = rnd[25:22];
      if (!(c_r inside {1, 2, 8, 10, 12}))
        p_r = 6'h0;
      if (c_r inside {8, 10, 12} || m_r || k_r)
        p_r = p_r & 6'h01;
      repeat (5) @(posedge clk_sys);
      #2;
      run(m_r, k_r, c_r, p_r);
    end
    complete_run;
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial
  begin
    #(25 * 20000);
    n_fail++;
    complete_run;
  end
endmodule
`default_nettype wire
